// ### rtl/tpt_pkg.sv
// Purpose: Shared constants and carrier types for the straight-track pattern trigger.
// Assumes: Core clock 250 MHz; pixel trigger bus clocked by the 10 MHz system clock.
// Notes:   Pattern geometry is loaded at run time, so no shape is hard-coded here.
//
// Operation
// - Each 100 ns select a neighbouring board pair on four lines, collect 44+2 bits.
// - Pixel trigger bus transfers run synchronously on the central 10 MHz clock.
// - Every 50 ns load one board column, 22 pixels plus parity, into column store.
// - Scan covers whole matrix column by column within 1 us, analysis concurrent.
// - Track search runs on a sliding 22 row by 5 column window.
// - Candidates come from five basic shapes plus all rotations and mirror images.
// - A match needs any four of the five pixels of a shape triggered.
// - Four-pixel matches fall into exactly 108 classes, shared gapped sets merged.
// - Coincidence uses 2102 four-input AND terms, ORed per class.
// - Decoder yields a 7-bit class result and a multiplicity indication.
// - No class matched gives result zero and multiplicity zero.
// - Exactly one class gives result equal to its number 1..108, multiplicity one.
// - Two or more classes give result 127, multiplicity at least two.
// - Any nonzero result raises the internal track trigger.
// - Report a pattern only if the leftmost window column holds a triggered pixel.
// - Every 50 ns write reference pixels, parity error, external, neighbour, result.
// - Pixel memory is synchronous dual-port 64K x 32, in 32 pages.
// - Memory ports run independently: writes at the 20 MHz word rate, reads on any core clock.
// - Active memory page always equals the boards' circular buffer page.
// - On next-page strobe the write page switches to the supplied page address.
// - Write address is an 11-bit counter stepping each 50 ns through 0..1999.

package tpt_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int ROWS = 22;
    localparam int COLS = 20;
    localparam int WIN_COLS = 5;
    localparam int WIN_PIX = ROWS * WIN_COLS;
    localparam int PAIRS = COLS / 2;
    localparam int NTERMS = 2102;
    localparam int NCLASSES = 108;
    localparam int LAST_REF_COL = COLS - WIN_COLS;

    // ************************************************************
    // Class result codes
    // ************************************************************
    localparam logic [6:0] RES_NONE = 7'h00;
    localparam logic [6:0] RES_MULTI = 7'h7f;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_COLUMN_NS = 50;
    localparam int CYC_COLUMN = ((T_COLUMN_NS * 1000) / CLK_PERIOD_PS < 1) ? 1
                                : (T_COLUMN_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] CYC_COLUMN_M1 = 4'(CYC_COLUMN - 1);

    // ************************************************************
    // Pixel memory layout
    // ************************************************************
    localparam int MEM_AW = 16;
    localparam int PAGE_W = 5;
    localparam int SLOT_W = 11;
    localparam logic [10:0] SLOT_LAST = 11'h7cf;
    localparam logic [4:0] PAGE_RESET = 5'h00;
    localparam logic [3:0] PAIR_LAST = 4'(PAIRS - 1);

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic parity;
        logic [ROWS-1:0] pix;
    } tpt_col_t;

    typedef struct packed {
        tpt_col_t col_b;
        tpt_col_t col_a;
    } tpt_bus_word_t;

    typedef struct packed {
        logic [6:0] cls;
        logic [6:0] pix3;
        logic [6:0] pix2;
        logic [6:0] pix1;
        logic [6:0] pix0;
    } tpt_pat_t;

    typedef struct packed {
        logic [6:0] result;
        logic neighbour_trig;
        logic ext_trig;
        logic parity_err;
        logic [ROWS-1:0] ref_pix;
    } tpt_mem_word_t;

endpackage : tpt_pkg

// ### rtl/tpt_track_finder.sv
// Purpose: Polls board pairs, slides a 22x5 window, classifies tracks, fills pixel memory.
// Assumes: link_clk is the 10 MHz system clock that also clocks the boards.
// Notes:   Pattern table is empty after reset; class code 0 marks an unused term.
`timescale 1ns/1ps

module tpt_track_finder
    import tpt_pkg::*;
#(
    parameter bit PARITY_ODD = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    output logic [3:0] board_sel,
    input wire tpt_bus_word_t trig_bus,
    input wire logic next_page_strobe,
    input wire logic [PAGE_W-1:0] new_page,
    input wire logic external_calibration_trigger,
    input wire logic neighbour_trigger,
    input wire logic pat_we,
    input wire logic [11:0] pat_addr,
    input wire tpt_pat_t pat_data,
    input wire logic rd_en,
    input wire logic [MEM_AW-1:0] rd_addr,
    output logic [31:0] rd_data,
    output logic rd_valid,
    output logic internal_track_trigger,
    output logic [6:0] class_result,
    output logic [1:0] class_mult
);

    // ************************************************************
    // Link domain reset: asserts at once, releases on link clock
    // ************************************************************
    logic lrst_s1_reg;
    logic lrst_n_reg;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_s1_reg <= 1'b0;
            lrst_n_reg <= 1'b0;
        end else begin
            lrst_s1_reg <= 1'b1;
            lrst_n_reg <= lrst_s1_reg;
        end
    end

    // ************************************************************
    // Pixel trigger bus poller (link domain)
    // ************************************************************
    logic [3:0] pair_reg;
    logic [3:0] pair_next;
    tpt_bus_word_t lword_reg;
    logic [3:0] lword_pair_reg;
    logic ltog_reg;

    // Board pair counter wraps after the last pair, one pair per system clock
    assign pair_next = (pair_reg == PAIR_LAST) ? 4'h0 : pair_reg + 4'h1;
    assign board_sel = pair_reg;

    // Data answers the select of the previous edge; the toggle announces it
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            pair_reg <= 4'h0;
            lword_reg <= '0;
            lword_pair_reg <= 4'h0;
            ltog_reg <= 1'b0;
        end else begin
            pair_reg <= pair_next;
            lword_reg <= trig_bus;
            lword_pair_reg <= pair_reg; // Select still held up to this edge is the one answered
            ltog_reg <= ~ltog_reg;
        end
    end

    // ************************************************************
    // Crossing into the core domain
    // ************************************************************
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic arrival;

    // The word register stays put for a whole link period, far longer than the sync delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            tog_s3_reg <= 1'b0;
        end else begin
            tog_s1_reg <= ltog_reg;
            tog_s2_reg <= tog_s1_reg;
            tog_s3_reg <= tog_s2_reg;
        end
    end

    assign arrival = tog_s2_reg ^ tog_s3_reg;

    // Asynchronous pins: two flops before use
    logic [2:0] np_sync_reg;
    logic [PAGE_W-1:0] pg_s1_reg;
    logic [PAGE_W-1:0] pg_s2_reg;
    logic [1:0] ext_sync_reg;
    logic [1:0] nb_sync_reg;
    logic page_switch;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_sync_reg <= 3'h0;
            pg_s1_reg <= PAGE_RESET;
            pg_s2_reg <= PAGE_RESET;
            ext_sync_reg <= 2'h0;
            nb_sync_reg <= 2'h0;
        end else begin
            np_sync_reg <= {np_sync_reg[1:0], next_page_strobe};
            pg_s1_reg <= new_page;
            pg_s2_reg <= pg_s1_reg;
            ext_sync_reg <= {ext_sync_reg[0], external_calibration_trigger};
            nb_sync_reg <= {nb_sync_reg[0], neighbour_trigger};
        end
    end

    // Rising edge seen between the second and third stage only
    assign page_switch = np_sync_reg[1] & ~np_sync_reg[2];

    // ************************************************************
    // Column sequencer: A one cycle after arrival, B one column period after A
    // ************************************************************
    tpt_bus_word_t word_reg;
    logic [3:0] word_pair_reg;
    logic pend_a_reg;
    logic pend_b_reg;
    logic [3:0] timer_reg;
    logic shift_b;
    logic shift_a;
    logic shift;
    tpt_col_t new_col;
    logic [4:0] new_idx;
    logic new_perr;

    // A late B is forced out by the next arrival so no column is lost
    assign shift_b = pend_b_reg & (arrival | (timer_reg == 4'h0));
    assign shift_a = pend_a_reg & ~shift_b;
    assign shift = shift_a | shift_b;
    assign new_col = shift_b ? word_reg.col_b : word_reg.col_a;
    assign new_idx = {word_pair_reg, shift_b};
    // Parity recomputed per column; sense chosen at build time
    assign new_perr = (^new_col.pix ^ PARITY_ODD) != new_col.parity;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg <= '0;
            word_pair_reg <= 4'h0;
        end else if (arrival) begin
            word_reg <= lword_reg;
            word_pair_reg <= lword_pair_reg;
        end
    end

    // Pending flags and column timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
            timer_reg <= 4'h0;
        end else begin
            if (arrival) begin
                pend_a_reg <= 1'b1;
            end else if (shift_a) begin
                pend_a_reg <= 1'b0;
            end
            if (shift_a) begin
                pend_b_reg <= 1'b1;
                timer_reg <= CYC_COLUMN_M1;
            end else if (shift_b) begin
                pend_b_reg <= 1'b0;
            end else if (pend_b_reg && timer_reg != 4'h0) begin
                timer_reg <= timer_reg - 4'h1;
            end
        end
    end

    // ************************************************************
    // Sliding 22x5 window, leftmost column in slot 0
    // ************************************************************
    logic [ROWS-1:0] win_reg [WIN_COLS];
    logic [4:0] widx_reg [WIN_COLS];
    logic [WIN_COLS-1:0] wvalid_reg;
    logic [WIN_COLS-1:0] wperr_reg;

    // New column enters on the right; analysis runs every cycle alongside loading
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < WIN_COLS; c++) begin
                win_reg[c] <= '0;
                widx_reg[c] <= 5'h00;
            end
            wvalid_reg <= '0;
            wperr_reg <= '0;
        end else if (shift) begin
            for (int c = 0; c < WIN_COLS - 1; c++) begin
                win_reg[c] <= win_reg[c+1];
                widx_reg[c] <= widx_reg[c+1];
            end
            win_reg[WIN_COLS-1] <= new_col.pix;
            widx_reg[WIN_COLS-1] <= new_idx;
            wvalid_reg <= {1'b1, wvalid_reg[WIN_COLS-1:1]};
            wperr_reg <= {new_perr, wperr_reg[WIN_COLS-1:1]};
        end
    end

    // Flat pixel vector: index = column * 22 + row, padded so any 7-bit index is safe
    logic [127:0] win_flat;

    always_comb begin
        win_flat = '0;
        for (int c = 0; c < WIN_COLS; c++) begin
            win_flat[c*ROWS +: ROWS] = win_reg[c];
        end
    end

    // ************************************************************
    // Loadable pattern table
    // ************************************************************
    tpt_pat_t pat_reg [NTERMS];

    // Geometry of every shape, rotation and mirror lives here, not in gates
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int t = 0; t < NTERMS; t++) begin
                pat_reg[t] <= '0;
            end
        end else if (pat_we && pat_addr < 12'(NTERMS)) begin
            pat_reg[pat_addr] <= pat_data;
        end
    end

    // ************************************************************
    // Coincidence: four-input AND terms, ORed per class
    // ************************************************************
    logic [NTERMS-1:0] term_hit;

    // Any four of a five-pixel shape form one term, so one missing pixel is tolerated
    for (genvar g = 0; g < NTERMS; g++) begin : g_term
        assign term_hit[g] = (pat_reg[g].cls != 7'h00)
                             & win_flat[pat_reg[g].pix0] & win_flat[pat_reg[g].pix1]
                             & win_flat[pat_reg[g].pix2] & win_flat[pat_reg[g].pix3];
    end

    logic [127:0] class_or;

    // Terms sharing a class code merge, which also folds duplicated gapped sets
    always_comb begin
        class_or = '0;
        for (int t = 0; t < NTERMS; t++) begin
            if (term_hit[t]) begin
                class_or[pat_reg[t].cls - 7'h01] = 1'b1;
            end
        end
    end

    // ************************************************************
    // Decoder and reference column gate
    // ************************************************************
    logic [NCLASSES-1:0] class_hit;
    logic scan_ok;
    logic [6:0] first_cls;
    logic found;
    logic many;
    logic [6:0] result;
    logic [1:0] mult;

    // Window must hold five columns of one scan, and the leftmost one must fire
    assign scan_ok = (&wvalid_reg) && (widx_reg[0] <= 5'(LAST_REF_COL)) && (|win_reg[0]);
    assign class_hit = scan_ok ? class_or[NCLASSES-1:0] : '0;

    always_comb begin
        first_cls = RES_NONE;
        found = 1'b0;
        many = 1'b0;
        for (int i = 0; i < NCLASSES; i++) begin
            if (class_hit[i]) begin
                if (found) begin
                    many = 1'b1;
                end else begin
                    first_cls = 7'(i + 1);
                    found = 1'b1;
                end
            end
        end
    end

    // Three outcomes: none, a single class number, or the multi-class code
    assign result = many ? RES_MULTI : (found ? first_cls : RES_NONE);
    assign mult = many ? 2'h2 : (found ? 2'h1 : 2'h0);

    // ************************************************************
    // Pixel memory write side
    // ************************************************************
    logic shift_d_reg;
    logic [PAGE_W-1:0] page_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic [SLOT_W-1:0] slot_next;
    tpt_mem_word_t wr_word;
    logic [MEM_AW-1:0] wr_addr;

    // Writes one cycle after each shift so the decoder sees the settled window
    assign wr_word.result = result;
    assign wr_word.neighbour_trig = nb_sync_reg[1];
    assign wr_word.ext_trig = ext_sync_reg[1];
    assign wr_word.parity_err = wperr_reg[0];
    assign wr_word.ref_pix = win_reg[0];
    assign wr_addr = {page_reg, slot_reg};
    assign slot_next = (slot_reg == SLOT_LAST) ? '0 : slot_reg + 11'h001;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_d_reg <= 1'b0;
        end else begin
            shift_d_reg <= shift;
        end
    end

    // Page follows the board buffers; slot counter keeps its frame position
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            page_reg <= PAGE_RESET;
            slot_reg <= '0;
        end else begin
            if (page_switch) begin
                page_reg <= pg_s2_reg;
            end
            if (shift_d_reg) begin
                slot_reg <= slot_next;
            end
        end
    end

    // ************************************************************
    // Dual-port store: write port and read port independent
    // ************************************************************
    logic [31:0] mem [2**MEM_AW];

    // No reset on the array; a block RAM cannot clear itself
    always_ff @(posedge clk) begin
        if (shift_d_reg) begin
            mem[wr_addr] <= wr_word;
        end
    end

    logic [31:0] rd_raw;

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_raw <= mem[rd_addr];
        end
    end

    // Read answer lands one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
        end
    end

    assign rd_data = rd_valid ? rd_raw : 32'h0000_0000;

    // ************************************************************
    // Result and trigger outputs, held for one column period
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            class_result <= RES_NONE;
            class_mult <= 2'h0;
            internal_track_trigger <= 1'b0;
        end else if (shift_d_reg) begin
            class_result <= result;
            class_mult <= mult;
            internal_track_trigger <= (result != RES_NONE);
        end
    end

endmodule : tpt_track_finder

// ### testbench/tb_track_pattern_trigger.sv
// Purpose: Self-checking bench of the track pattern trigger.
// Assumes: Link clock 30 ns, unrelated to the 4 ns core clock.
// Notes:   Results noted in queues, checked by a watcher.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_track_pattern_trigger
    import tpt_pkg::*;
;
    logic clk = 0, rst_n = 0, link_clk = 0, next_page_strobe = 0, ext = 0, neigh = 0;
    logic pat_we = 0, rd_en = 0, rd_valid, trig, trig_q = 0, bad;
    logic [3:0] board_sel;
    logic [4:0] new_page = '0;
    logic [11:0] pat_addr = '0;
    logic [15:0] rd_addr = '0;
    logic [31:0] rd_data, w;
    logic [6:0] res;
    logic [1:0] mult;
    logic [21:0] p;
    tpt_bus_word_t trig_bus;
    tpt_pat_t pat_data = '0;
    logic [8:0] cq[$];
    logic [31:0] rq[$];
    int error_cnt = 0, compares = 0;
    bit watch = 0;

    // ******
    // Clocks, parts
    // ******
    initial forever #2 clk = ~clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    tpt_track_finder i_tpt_track_finder (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
        .board_sel(board_sel), .trig_bus(trig_bus), .next_page_strobe(next_page_strobe),
        .new_page(new_page), .external_calibration_trigger(ext), .neighbour_trigger(neigh),
        .pat_we(pat_we), .pat_addr(pat_addr), .pat_data(pat_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .internal_track_trigger(trig),
        .class_result(res), .class_mult(mult));
    tpt_board_model i_tpt_board_model (.link_clk(link_clk), .board_sel(board_sel), .trig_bus(trig_bus));

    // ******
    // Tasks
    // ******
    task automatic close_out();
        if (error_cnt == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic pat(int a, tpt_pat_t d);
        @(negedge clk);
        pat_we = 1;
        pat_addr = 12'(a);
        pat_data = d;
        @(negedge clk);
        pat_we = 0;
    endtask : pat

    // Back-to-back reads, each answer noted first
    task automatic rd_run(logic [15:0] a, int n, logic [31:0] e);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rq.push_back(e);
            rd_en = 1;
            rd_addr = a + 16'(i);
        end
        @(negedge clk);
        rd_en = 0;
    endtask : rd_run

    // Let a new matrix travel through a full scan before watching
    task automatic settle();
        repeat (200) @(negedge clk);
        watch = 1;
    endtask : settle

    task automatic expect_cls(logic [8:0] e);
        int n = 0;
        repeat (2) cq.push_back(e);
        while (cq.size() != 0 && n < 600) begin
            @(negedge clk);
            n++;
        end
        `CHK(cq.size(), 0)
        watch = 0;
    endtask : expect_cls

    // ******
    // Watcher: reads and rising triggers
    // ******
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (rq.size() == 0) `CHK(rd_valid, 1'b0) else `CHK(rd_data, rq.pop_front())
        end
        if (watch && trig === 1'b1 && trig_q !== 1'b1) begin
            if (cq.size() == 0) `CHK(res, RES_NONE) else `CHK({mult, res}, cq.pop_front())
        end
        trig_q <= trig;
    end

    // Watchdog, well past the planned run
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    // ******
    // Main sequence
    // ******
    initial begin
        void'($urandom(32'h16ae517f));
        repeat (8) @(negedge clk);
        rst_n = 1;
        watch = 1;
        repeat (300) @(negedge clk);
        watch = 0;
        // Diagonal with its fifth pixel missing, then a second class on top
        pat(0, '{7'h05, 7'h47, 7'h30, 7'h19, 7'h02});
        for (int c = 0; c < 4; c++) i_tpt_board_model.mat[3 + c][2 + c] = 1'b1;
        settle();
        expect_cls({2'h1, 7'h05});
        pat(1, '{7'h09, 7'h5e, 7'h30, 7'h19, 7'h02});
        i_tpt_board_model.mat[7][6] = 1'b1;
        settle();
        expect_cls({2'h2, RES_MULTI});
        // Empty leftmost column must hide a match
        pat(0, '0);
        pat(1, '0);
        pat(2, '{7'h07, 7'h65, 7'h4e, 7'h37, 7'h20});
        foreach (i_tpt_board_model.mat[c]) i_tpt_board_model.mat[c] = '0;
        for (int c = 0; c < 4; c++) i_tpt_board_model.mat[4 + c][10 + c] = 1'b1;
        settle();
        repeat (300) @(negedge clk);
        watch = 0;
        i_tpt_board_model.mat[3][0] = 1'b1;
        settle();
        expect_cls({2'h1, 7'h07});
        // Second reset, flat random matrix, random status levels
        p = 22'($urandom);
        bad = 1'($urandom);
        ext = 1'($urandom);
        neigh = 1'($urandom);
        foreach (i_tpt_board_model.mat[c]) i_tpt_board_model.mat[c] = p;
        i_tpt_board_model.bad = {COLS{bad}};
        rst_n = 0;
        repeat (30) @(negedge clk);
        rst_n = 1;
        repeat (2000) @(negedge clk);
        w = {RES_NONE, neigh, ext, bad, p};
        rd_run({5'h00, 11'h028}, 24, w);
        // Page switch, then a full slot lap on the new page
        new_page = 5'h03;
        repeat (8) @(negedge clk);
        next_page_strobe = 1;
        foreach (i_tpt_board_model.mat[c]) i_tpt_board_model.mat[c] = ~p;
        repeat (9000) @(negedge clk);
        rd_run({5'h00, 11'h028}, 4, w);
        // Last two slots of the lap, then slot 0 after the wrap; slots past 1999 stay unwritten
        rd_run({5'h03, 11'h7ce}, 2, {RES_NONE, neigh, ext, bad, ~p});
        rd_run({5'h03, 11'h000}, 1, {RES_NONE, neigh, ext, bad, ~p});
        close_out();
    end
endmodule : tb_track_pattern_trigger

// ### testbench/tpt_board_model.sv
// Purpose: First-level boards answering the pair select.
// Assumes: Matrix and parity faults set by the bench.
// Notes:   Answer lands 1 ns after the select edge.
`timescale 1ns/1ps

module tpt_board_model
    import tpt_pkg::*;
#(
    parameter bit PAR_ODD = 1'b1
) (
    input wire logic link_clk,
    input wire logic [3:0] board_sel,
    output tpt_bus_word_t trig_bus
);
    logic [ROWS-1:0] mat [COLS];
    logic [COLS-1:0] bad = '0;

    // One board column with its parity, flipped on a forced fault
    function automatic tpt_col_t col_of(int c);
        return tpt_col_t'({^mat[c] ^ PAR_ODD ^ bad[c], mat[c]});
    endfunction : col_of

    // Answer the select just taken, held for the whole link period
    initial begin
        foreach (mat[c]) mat[c] = '0;
        trig_bus = '0;
        forever begin
            @(posedge link_clk);
            #1;
            trig_bus = {col_of(2 * int'(board_sel) + 1), col_of(2 * int'(board_sel))};
        end
    end
endmodule : tpt_board_model

// ### testbench/tpt_checker_sva.sv
// Purpose: Port checks of the track pattern trigger.
// Assumes: Sees only ports of tpt_track_finder.
// Notes:   Core and link domains checked apart.
`timescale 1ns/1ps

module tpt_checker
    import tpt_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic [3:0] board_sel,
    input wire logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic internal_track_trigger,
    input wire logic [6:0] class_result,
    input wire logic [1:0] class_mult
);
    // ******
    // Read port
    // ******
    rd_answer_a: assert property (@(posedge clk) disable iff (!rst_n) rd_en |=> rd_valid)
        else $error("read got no answer");
    rd_idle_a: assert property (@(posedge clk) disable iff (!rst_n) !rd_en |=> !rd_valid)
        else $error("answer without read");
    rd_zero_a: assert property (@(posedge clk) disable iff (!rst_n) !rd_valid |-> rd_data == 32'h0)
        else $error("read data not cleared");
    // ******
    // Decoder, result codes tie to multiplicity
    // ******
    trig_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        internal_track_trigger == (class_result != RES_NONE))
        else $error("trigger disagrees with result");
    trig_mult_a: assert property (@(posedge clk) disable iff (!rst_n)
        internal_track_trigger == (class_mult != 2'h0))
        else $error("trigger disagrees with multiplicity");
    none_mult_a: assert property (@(posedge clk) disable iff (!rst_n)
        class_result == RES_NONE |-> class_mult == 2'h0)
        else $error("empty result with multiplicity");
    single_mult_a: assert property (@(posedge clk) disable iff (!rst_n)
        class_result >= 7'h01 && class_result <= 7'h6c |-> class_mult == 2'h1)
        else $error("single class with wrong multiplicity");
    multi_mult_a: assert property (@(posedge clk) disable iff (!rst_n)
        class_result == RES_MULTI |-> class_mult == 2'h2)
        else $error("multi code with wrong multiplicity");
    class_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        class_result <= 7'h6c || class_result == RES_MULTI)
        else $error("result code out of range");
    // ******
    // Link domain, pair select order
    // ******
    sel_range_a: assert property (@(posedge link_clk) disable iff (!rst_n) board_sel <= 4'h9)
        else $error("pair select beyond last pair");
    sel_step_a: assert property (@(posedge link_clk) disable iff (!rst_n) $changed(board_sel)
        |-> board_sel == (($past(board_sel) == 4'h9) ? 4'h0 : $past(board_sel) + 4'h1))
        else $error("pair select skipped");
    // Main scenarios reached
    cover property (@(posedge clk) class_mult == 2'h1);
    cover property (@(posedge clk) class_mult == 2'h2);
    cover property (@(posedge clk) rd_valid && rd_en);
endmodule : tpt_checker

bind tpt_track_finder tpt_checker i_tpt_checker (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .board_sel(board_sel), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .internal_track_trigger(internal_track_trigger), .class_result(class_result), .class_mult(class_mult));
